// file: dv/tb_gpio_wake_status_regs.sv
/*
 * tb_gpio_wake_status_regs: self-checking bench for gwsr_top with a queue-free
 * integer model of status, enables, interrupt status and mask.
 * Assumes gwsr_pkg register indices and a classic Wishbone slave port.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_gpio_wake_status_regs;

    // ------------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------------
    logic                 clk_i, rst_i, standby_por_i, cyc_i, stb_i, we_i;
    gwsr_pkg::gwsr_pins_t gpin_i;
    logic [11:0]          adr_i;
    logic [3:0]           sel_i;
    logic [31:0]          dat_i, dat_o, rdat;
    logic                 ack_o, wake_event_out_n_o, irq_o;
    int                   bad_count, total_checks, seed, g, k;
    logic [7:0]           sts_m [4];
    logic [7:0]           en_m  [4];
    logic [3:0]           irq_m, mask_m;
    logic                 gen_m;
    logic [31:0]          p;
    logic [3:0]           sel_v;
    logic [9:0]           sts_idx [4] = '{gwsr_pkg::IDX_STS_1X, gwsr_pkg::IDX_STS_2X,
                                          gwsr_pkg::IDX_STS_MIXED, gwsr_pkg::IDX_STS_5X};
    logic [9:0]           en_idx [4]  = '{gwsr_pkg::IDX_EN_1X, gwsr_pkg::IDX_EN_2X,
                                          gwsr_pkg::IDX_EN_MIXED, gwsr_pkg::IDX_EN_5X};

    gwsr_top dut (
        .clk_i(clk_i), .rst_i(rst_i), .standby_por_i(standby_por_i), .gpin_i(gpin_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .wake_event_out_n_o(wake_event_out_n_o), .irq_o(irq_o)
    );

    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // compare, bus and stimulus tasks
    // ------------------------------------------------------------------
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk_pin

    // one classic cycle; request held until ack is sampled high at an edge
    task automatic wb(input logic we, input logic [9:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= we;
        adr_i <= {idx, 2'b00};
        dat_i <= d;
        sel_i <= sel_v;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            $display("CHECK FAILED t=%0t no bus answer", $time);
        end
        rdat  = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input string what);
        wb(1'b0, idx, 32'h0);
        chk_reg(rdat, exp, what);
    endtask : rd_chk

    // rising edges on the pins in pat, then all pins low again; model updates sticky bits
    task automatic pulse(input logic [31:0] pat);
        gpin_i <= pat;
        repeat (4) @(posedge clk_i);
        gpin_i <= 32'h0;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 4; i++) begin
            sts_m[i] = sts_m[i] | pat[8*i +: 8];
            if (pat[8*i +: 8] != 8'h00) irq_m[i] = 1'b1;
        end
    endtask : pulse

    task automatic chk_all_sts(input string what);
        for (int i = 0; i < 4; i++) rd_chk(sts_idx[i], {24'h0, sts_m[i]}, what);
    endtask : chk_all_sts

    task automatic chk_outs();
        logic w;
        w = 1'b0;
        for (int i = 0; i < 4; i++) w = w | (|(sts_m[i] & en_m[i]));
        repeat (3) @(posedge clk_i);
        chk_pin(wake_event_out_n_o, ~(w & gen_m), "wake output");
        chk_pin(irq_o, |(irq_m & mask_m), "irq level");
    endtask : chk_outs

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_i, standby_por_i, cyc_i, stb_i, we_i} = 5'h18;
        {adr_i, sel_i, dat_i} = '0;
        gpin_i = 32'h0;
        sel_v = 4'hF;
        bad_count = 0; total_checks = 0; seed = 32'h440c;
        for (int i = 0; i < 4; i++) begin sts_m[i] = 8'h00; en_m[i] = 8'h00; end
        {irq_m, mask_m, gen_m} = 9'h0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0; standby_por_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk_all_sts("reset value");
        rd_chk(gwsr_pkg::IDX_GLOBAL_EN, 32'h0, "global enable reset");
        wb(1'b1, 10'h0FF, 32'hFFFFFFFF);
        rd_chk(10'h0FF, 32'h0, "unmapped read");
        $display("test reset done");
        // events with every enable off still set status; mask off keeps irq low
        for (k = 0; k < 4; k++) begin
            p = $random(seed);
            pulse(p);
            chk_all_sts("sticky events");
            chk_outs();
        end
        rd_chk(gwsr_pkg::IDX_IRQ_STS, {28'h0, irq_m}, "irq status");
        irq_m = 4'h0;
        rd_chk(gwsr_pkg::IDX_IRQ_STS, 32'h0, "irq status read clear");
        $display("test events done");
        // interrupt masked in, raised, then cleared by read
        mask_m = 4'hF;
        wb(1'b1, gwsr_pkg::IDX_IRQ_MASK, {28'h0, mask_m});
        pulse(32'h01000000);
        chk_outs();
        rd_chk(gwsr_pkg::IDX_IRQ_STS, {28'h0, irq_m}, "irq status masked in");
        irq_m = 4'h0;
        chk_outs();
        $display("test interrupt done");
        // write zero keeps, write one clears
        for (g = 0; g < 4; g++) begin
            wb(1'b1, sts_idx[g], 32'h0);
            chk_all_sts("write zero");
            p = $random(seed);
            wb(1'b1, sts_idx[g], {24'h0, p[7:0]});
            sts_m[g] = sts_m[g] & ~p[7:0];
            chk_all_sts("write one clear");
        end
        // pin raised so its event lands on the very edge the clear acts on
        gpin_i <= 32'h00000002;
        @(posedge clk_i);
        wb(1'b1, sts_idx[0], 32'h03);
        gpin_i <= 32'h0;
        repeat (4) @(posedge clk_i);
        sts_m[0] = (sts_m[0] & 8'hFC) | 8'h02;
        irq_m[0] = 1'b1;
        chk_all_sts("event beats clear");
        // a write with byte lane 0 off must not clear anything
        sel_v = 4'hE;
        wb(1'b1, sts_idx[0], 32'hFF);
        sel_v = 4'hF;
        chk_all_sts("lane off write");
        $display("test clear done");
        // wake output needs status, source enable and global enable together
        pulse(32'h80000001);
        en_m[0] = 8'h01;
        wb(1'b1, en_idx[0], 32'h01);
        chk_outs();
        gen_m = 1'b1;
        wb(1'b1, gwsr_pkg::IDX_GLOBAL_EN, 32'h1);
        chk_outs();
        wb(1'b1, sts_idx[0], 32'h01);
        sts_m[0] = sts_m[0] & 8'hFE;
        chk_outs();
        en_m[3] = 8'h80;
        wb(1'b1, en_idx[3], 32'h80);
        chk_outs();
        gen_m = 1'b0;
        wb(1'b1, gwsr_pkg::IDX_GLOBAL_EN, 32'h0);
        chk_outs();
        $display("test wake done");
        // main reset keeps status; standby reset clears it
        pulse(32'h5A3C0FF0);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        mask_m = 4'h0;
        irq_m = 4'h0;
        rd_chk(gwsr_pkg::IDX_IRQ_STS, 32'h0, "irq status after main reset");
        chk_all_sts("after main reset");
        rd_chk(en_idx[3], 32'h80, "enable kept by main reset");
        chk_outs();
        standby_por_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        standby_por_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 4; i++) begin sts_m[i] = 8'h00; en_m[i] = 8'h00; end
        chk_all_sts("after standby reset");
        rd_chk(en_idx[3], 32'h0, "enable after standby reset");
        $display("test resets done");
        end_of_test();
    end

endmodule : tb_gpio_wake_status_regs

`default_nettype wire

// file: rtl/gwsr_edge_sync.sv
/*
 * gwsr_edge_sync: two-flop synchroniser and rising-edge detector per pin.
 * Assumes pins are asynchronous to clk_i; rst_i is synchronous, active high.
 */
`timescale 1ns/1ps
`default_nettype none

module gwsr_edge_sync #(
    parameter int W = 32
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] pins_i,
    output logic      [W-1:0] rise_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;
    logic [1:0]   prime_q;
    logic [1:0]   prime_d;

    // ------------------------------------------------------------------
    // priming counter
    // ------------------------------------------------------------------
    // edges are masked until prev_q holds real pin history, so a pin that
    // is already high at reset release does not fake a wake event
    always_comb begin
        prime_d = prime_q;
        if (prime_q != gwsr_pkg::SYNC_PRIME_CNT) begin
            prime_d = prime_q + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prime_q <= 2'h0;
        end else begin
            prime_q <= prime_d;
        end
    end

    // ------------------------------------------------------------------
    // per-pin synchroniser; meta_q feeds sync_q only
    // ------------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_pin
        always_ff @(posedge clk_i) begin
            meta_q[i] <= pins_i[i];
            sync_q[i] <= meta_q[i];
            prev_q[i] <= sync_q[i];
        end
        assign rise_o[i] = sync_q[i] & ~prev_q[i] & (prime_q == gwsr_pkg::SYNC_PRIME_CNT);
    end

endmodule : gwsr_edge_sync

`default_nettype wire

// file: rtl/gwsr_top.sv
/*
 * gwsr_top: sticky wake-status registers for thirty-two general-purpose pins,
 * per-source and global wake enables, active-low wake output, and an
 * interrupt summarising new wake events, behind a classic Wishbone slave.
 * Assumes: clk_i 50 MHz; rst_i (main/soft/hard reset) and standby_por_i are
 * synchronous to clk_i and active high; wake pins are asynchronous.
 */
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - a wake event on a pin sets its status bit; it stays until cleared
// - status bits record events whatever the per-source and global enables
// - writing one to a status bit clears it; the value is not stored
// - writing zero to a status bit leaves it unchanged
// - main-supply, soft and hard resets leave the status bits untouched
// - the standby power-on reset clears every wake status register to zero
// - index 05 holds pins 1_0 to 1_7 in bits 0 to 7
// - index 06 holds pins 2_0 to 2_7 in bits 0 to 7
// - index 07 holds pins 3_0..3_3, 4_1, 4_3, 6_0, 6_1 in bits 0 to 7
// - index 80 holds pins 5_0 to 5_7 in bits 0 to 7
// - wake output active only for a set, enabled source with global enable set
// - global enable bit 0 allows the wake output when one; resets to zero
module gwsr_top (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                standby_por_i,
    input  wire gwsr_pkg::gwsr_pins_t gpin_i,
    // classic Wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [11:0]         adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic      [31:0]         dat_o,
    output logic                     ack_o,
    // wake and interrupt outputs
    output logic                     wake_event_out_n_o,
    output logic                     irq_o
);

    localparam int NGRP = 4;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [NGRP-1:0][7:0] sts_q, sts_d;     // wake status, index by group
    logic [NGRP-1:0][7:0] en_q, en_d;       // per-source enables
    logic                 gen_q, gen_d;     // global wake enable
    logic [NGRP-1:0]      irq_sts_q, irq_sts_d;
    logic [NGRP-1:0]      irq_mask_q, irq_mask_d;
    logic                 ack_q, ack_d;
    logic [31:0]          dat_q, dat_d;
    logic                 wake_n_q, wake_n_d;
    logic                 irq_q, irq_d;

    logic [NGRP-1:0][7:0] ev;               // one-cycle rising-edge events
    logic [NGRP-1:0][7:0] clr;              // write-one-to-clear strobes
    logic [NGRP-1:0]      grp_ev;
    logic [NGRP-1:0]      irq_rdclr;
    logic                 sync_rst;
    logic [9:0]           idx;
    logic                 req;
    logic                 wr_ack;
    logic                 rd_ack;
    logic [NGRP-1:0]      sts_hit;
    logic [NGRP-1:0]      en_hit;

    // ------------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------------
    assign sync_rst = rst_i | standby_por_i;

    gwsr_edge_sync #(
        .W (32)
    ) u_sync (
        .clk_i  (clk_i),
        .rst_i  (sync_rst),
        .pins_i (gpin_i),
        .rise_o (ev)
    );

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // write and read-clear take effect on the ack edge only, so a held
    // request cannot act twice
    assign idx    = adr_i[11:2];
    assign req    = cyc_i & stb_i;
    assign wr_ack = req & ack_q & we_i & sel_i[0];
    assign rd_ack = req & ack_q & ~we_i;

    assign sts_hit[0] = (idx == gwsr_pkg::IDX_STS_1X);
    assign sts_hit[1] = (idx == gwsr_pkg::IDX_STS_2X);
    assign sts_hit[2] = (idx == gwsr_pkg::IDX_STS_MIXED);
    assign sts_hit[3] = (idx == gwsr_pkg::IDX_STS_5X);
    assign en_hit[0]  = (idx == gwsr_pkg::IDX_EN_1X);
    assign en_hit[1]  = (idx == gwsr_pkg::IDX_EN_2X);
    assign en_hit[2]  = (idx == gwsr_pkg::IDX_EN_MIXED);
    assign en_hit[3]  = (idx == gwsr_pkg::IDX_EN_5X);

    // ------------------------------------------------------------------
    // wake status and enables, one group per generate pass
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NGRP; g++) begin : g_grp
        // only ones in the write data clear; zeros are ignored
        assign clr[g]    = (wr_ack && sts_hit[g]) ? dat_i[7:0] : 8'h00;
        assign grp_ev[g] = |ev[g];

        always_comb begin
            // event wins over a clear in the same cycle; enables not consulted
            sts_d[g] = (sts_q[g] & ~clr[g]) | ev[g];
            en_d[g]  = en_q[g];
            if (wr_ack && en_hit[g]) begin
                en_d[g] = dat_i[7:0];
            end
        end

        // only the standby reset touches these; rst_i is deliberately absent
        always_ff @(posedge clk_i) begin
            if (standby_por_i) begin
                sts_q[g] <= gwsr_pkg::STS_RST;
                en_q[g]  <= gwsr_pkg::EN_RST;
            end else begin
                sts_q[g] <= sts_d[g];
                en_q[g]  <= en_d[g];
            end
        end
    end

    // ------------------------------------------------------------------
    // global wake enable
    // ------------------------------------------------------------------
    always_comb begin
        gen_d = gen_q;
        if (wr_ack && idx == gwsr_pkg::IDX_GLOBAL_EN) begin
            gen_d = dat_i[gwsr_pkg::GLOBAL_EN_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (standby_por_i) begin
            gen_q <= gwsr_pkg::GLOBAL_EN_RST;
        end else begin
            gen_q <= gen_d;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status, mask and read data
    // ------------------------------------------------------------------
    // read-clear drops only the bits that were returned, so an event that
    // lands between capture and ack is kept for the next read
    assign irq_rdclr = (rd_ack && idx == gwsr_pkg::IDX_IRQ_STS) ? dat_q[NGRP-1:0] : '0;

    always_comb begin
        irq_sts_d  = (irq_sts_q & ~irq_rdclr) | grp_ev;
        irq_mask_d = irq_mask_q;
        if (wr_ack && idx == gwsr_pkg::IDX_IRQ_MASK) begin
            irq_mask_d = dat_i[NGRP-1:0];
        end
        ack_d = req & ~ack_q;
        dat_d = dat_q;
        if (req && !ack_q) begin
            dat_d = 32'h0000_0000;   // unmapped and reserved bits read zero
            if (idx == gwsr_pkg::IDX_GLOBAL_EN) begin
                dat_d[gwsr_pkg::GLOBAL_EN_BIT] = gen_q;
            end else if (idx == gwsr_pkg::IDX_IRQ_STS) begin
                dat_d[NGRP-1:0] = irq_sts_q;
            end else if (idx == gwsr_pkg::IDX_IRQ_MASK) begin
                dat_d[NGRP-1:0] = irq_mask_q;
            end else begin
                for (int k = 0; k < NGRP; k++) begin
                    if (sts_hit[k]) begin
                        dat_d[7:0] = sts_q[k];
                    end
                    if (en_hit[k]) begin
                        dat_d[7:0] = en_q[k];
                    end
                end
            end
        end
        // enabled source, set status and global enable all needed
        wake_n_d = ~(gen_q & (|(sts_q & en_q)));
        irq_d    = |(irq_sts_q & irq_mask_q);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_sts_q  <= gwsr_pkg::IRQ_STS_RST;
            irq_mask_q <= gwsr_pkg::IRQ_MASK_RST;
            ack_q      <= 1'b0;
            dat_q      <= 32'h0000_0000;
            wake_n_q   <= 1'b1;
            irq_q      <= 1'b0;
        end else begin
            irq_sts_q  <= irq_sts_d;
            irq_mask_q <= irq_mask_d;
            ack_q      <= ack_d;
            dat_q      <= dat_d;
            wake_n_q   <= wake_n_d;
            irq_q      <= irq_d;
        end
    end

    assign dat_o              = dat_q;
    assign ack_o              = ack_q;
    assign wake_event_out_n_o = wake_n_q;
    assign irq_o              = irq_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i | standby_por_i);

    sequence s_rd_ack(logic [9:0] ri);
        ack_q && req && !we_i && idx == ri;
    endsequence

    sequence s_wr_clear;
        wr_ack && (|sts_hit);
    endsequence

    a_event_sets_bit: assert property (
        (|ev) |=> ((sts_q & $past(ev)) == $past(ev)))
        else $error("wake event did not set its status bit");

    a_status_sticky: assert property (
        ##1 ((($past(sts_q) & ~$past(clr)) & ~sts_q) == '0))
        else $error("status bit dropped without a one written");

    a_one_write_clears: assert property (
        s_wr_clear ##0 (ev == '0) |=> ((sts_q & $past(clr)) == '0))
        else $error("write of one did not clear status bit");

    a_status_only_sets: assert property (
        ##1 (((sts_q & ~$past(sts_q)) & ~$past(ev)) == '0))
        else $error("status bit set without an event");

    a_wake_out_cause: assert property (
        ##1 ($past(rst_i) || (!wake_event_out_n_o == $past(gen_q && (|(sts_q & en_q))))))
        else $error("wake output does not follow enabled status");

    a_global_blocks: assert property (
        (!gen_q) [*2] |-> wake_event_out_n_o)
        else $error("wake output active with global enable clear");

    a_read_1x_map: assert property (
        s_rd_ack(gwsr_pkg::IDX_STS_1X) |-> dat_o[7:0] == $past(sts_q[0]))
        else $error("read of pins 1x status wrong");

    a_read_2x_map: assert property (
        s_rd_ack(gwsr_pkg::IDX_STS_2X) |-> dat_o[7:0] == $past(sts_q[1]))
        else $error("read of pins 2x status wrong");

    a_read_mix_map: assert property (
        s_rd_ack(gwsr_pkg::IDX_STS_MIXED) |-> dat_o[7:0] == $past(sts_q[2]))
        else $error("read of mixed pins status wrong");

    a_read_5x_map: assert property (
        s_rd_ack(gwsr_pkg::IDX_STS_5X) |-> dat_o[7:0] == $past(sts_q[3]))
        else $error("read of pins 5x status wrong");

    a_main_rst_keeps: assert property (@(posedge clk_i) disable iff (standby_por_i)
        rst_i |=> ((sts_q & ~$past(ev)) == ($past(sts_q) & ~$past(clr) & ~$past(ev))))
        else $error("main reset disturbed wake status");

    a_standby_clears: assert property (@(posedge clk_i) disable iff (1'b0)
        standby_por_i |=> (sts_q == '0 && !gen_q))
        else $error("standby reset did not clear status");

endmodule : gwsr_top

`default_nettype wire

// file: shared/gwsr_pkg.sv
/*
 * gwsr_pkg: constants and carrier types for the wake-status register block.
 * Assumes a 32-bit classic Wishbone slave port where each register takes one word;
 * a register's byte address is four times its index.
 */
package gwsr_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------------
    localparam logic [9:0] IDX_GLOBAL_EN   = 10'h002;
    localparam logic [9:0] IDX_STS_1X      = 10'h005;
    localparam logic [9:0] IDX_STS_2X      = 10'h006;
    localparam logic [9:0] IDX_STS_MIXED   = 10'h007;
    localparam logic [9:0] IDX_STS_5X      = 10'h080;
    localparam logic [9:0] IDX_EN_1X       = 10'h00B;
    localparam logic [9:0] IDX_EN_2X       = 10'h00C;
    localparam logic [9:0] IDX_EN_MIXED    = 10'h00D;
    localparam logic [9:0] IDX_EN_5X       = 10'h00E;
    localparam logic [9:0] IDX_IRQ_STS     = 10'h010;
    localparam logic [9:0] IDX_IRQ_MASK    = 10'h011;

    // ------------------------------------------------------------------
    // field positions and values after reset
    // ------------------------------------------------------------------
    localparam int         GLOBAL_EN_BIT   = 0;
    localparam logic [7:0] STS_RST         = 8'h00;
    localparam logic [7:0] EN_RST          = 8'h00;
    localparam logic       GLOBAL_EN_RST   = 1'b0;
    localparam logic [3:0] IRQ_STS_RST     = 4'h0;
    localparam logic [3:0] IRQ_MASK_RST    = 4'h0;

    // ------------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------------
    localparam logic [1:0] SYNC_PRIME_CNT  = 2'h3;  // cycles until edge detect is valid

    // ------------------------------------------------------------------
    // carrier: one byte per wake-status group, bit n = pin n of the group
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] pins_5x;      // gpin_5_0 .. gpin_5_7
        logic [7:0] pins_mixed;   // gpin_3_0..3_3, gpin_4_1, gpin_4_3, gpin_6_0, gpin_6_1
        logic [7:0] pins_2x;      // gpin_2_0 .. gpin_2_7
        logic [7:0] pins_1x;      // gpin_1_0 .. gpin_1_7
    } gwsr_pins_t;

endpackage : gwsr_pkg
